// ===== shared/aspc_pkg.sv
// constants, types and helpers of the serial port core
//--------------------------------------------------------------
// Behaviour
// - one byte data register: sends written char, returns received char.
// - bit timing comes from a free-running 8-bit baud timer.
// - any divisor 0..255 is a valid division factor.
// - baud is clock/(64(N+1)) low speed, clock/(16(N+1)) high speed.
// - NRZ frame: start, 8 or 9 data bits, one or two stop bits.
// - even, odd or no parity as configured.
// - power-on format is 8 data bits, no parity, one stop.
// - data bits go least significant first, both directions.
// - transmitter and receiver share one format and one baud rate.
// - with all three enables set, pins act as serial out and in.
// - transmit pin is high while no frame or break is sent.
// - clearing global enable releases pins and empties the buffer.
// - disable clears enables, break, data and error flags; sets idles.
// - disable keeps all other control bits and the divisor.
// - disable abandons any transfer in progress at once.
// - re-enable resumes with the kept configuration.
// - word length bit picks 8 or 9 bits, parity or address included.
// - parity type bit picks odd/even, parity enable switches it.
// - stop count applies to transmit only; receiver expects one stop.
// - with parity or address, last word bit carries it.
// - received parity bit is not stored as the top data bit.
// - with address detect, words with clear address bit are dropped.
// - break holds output low at least 13 bits after buffered data.
// - receive pin is sampled at 16 times baud; shifter at baud.
//--------------------------------------------------------------
package aspc_pkg;

  localparam logic [4:0] ASPC_OFF_DATA = 5'h00;
  localparam logic [4:0] ASPC_OFF_BAUD = 5'h04;
  localparam logic [4:0] ASPC_OFF_CTL1 = 5'h08;
  localparam logic [4:0] ASPC_OFF_CTL2 = 5'h0C;
  localparam logic [4:0] ASPC_OFF_STAT = 5'h10;

  localparam int          ASPC_CLK_HZ   = 10000000;
  localparam logic [1:0]  ASPC_LOW_DIV  = 2'h3;
  localparam logic [3:0]  ASPC_OVS_LAST = 4'hF;
  localparam logic [3:0]  ASPC_OVS_MID  = 4'h7;
  localparam logic [3:0]  ASPC_BRK_BITS = 4'hD;
  localparam logic [7:0]  ASPC_BAUD_RST = 8'h00;
  localparam logic [8:0]  ASPC_DATA_RST = 9'h000;

  typedef struct packed {
    logic en;
    logic nine;
    logic pen;
    logic odd;
    logic two_stop;
    logic brk;
    logic rx9;
    logic tx9;
  } aspc_ctl1_t;

  typedef struct packed {
    logic       transmit_enable;
    logic       receive_enable;
    logic       hs;
    logic       address_detect_enable;
    logic [3:0] rsvd;
  } aspc_ctl2_t;

  typedef struct packed {
    logic parity_error;
    logic nf;
    logic framing_error;
    logic ovr;
    logic tx_idle;
    logic rx_idle;
    logic tx_empty;
    logic rxav;
  } aspc_stat_t;

  localparam aspc_ctl1_t ASPC_CTL1_RST = 8'h00;
  localparam aspc_ctl2_t ASPC_CTL2_RST = 8'h00;

  // parity over the payload: 8 bits in 9-bit mode, 7 in 8-bit mode
  function automatic logic aspc_parity(input logic [8:0] w, input logic nine,
                                       input logic odd);
    aspc_parity = (nine ? ^w[7:0] : ^w[6:0]) ^ odd;
  endfunction : aspc_parity

endpackage : aspc_pkg

// ===== design/aspc_baud.sv
// baud timer producing the 16x oversampling tick
`timescale 1ns/10ps
module aspc_baud
  import aspc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [7:0] divisor,
  input  wire logic       high_speed,
  output logic            tick16
);

  logic [7:0] cnt_ff;
  logic [1:0] pre_ff;
  logic [10:0] gap_ff;
  logic        seen_ff;
  logic        chg_ff;

  // reload at terminal count so a new divisor lands cleanly
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt_ff <= 8'h00;
    end else if (cnt_ff == 8'h00) begin
      cnt_ff <= divisor;
    end else begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      pre_ff <= 2'h0;
    end else if (cnt_ff == 8'h00) begin
      pre_ff <= (pre_ff == ASPC_LOW_DIV) ? 2'h0 : pre_ff + 2'h1;
    end
  end

  assign tick16 = run && (cnt_ff == 8'h00) && (high_speed || pre_ff == ASPC_LOW_DIV);

  // helper for the period check
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      gap_ff  <= 11'h000;
      seen_ff <= 1'b0;
      chg_ff  <= 1'b0;
    end else begin
      gap_ff  <= tick16 ? 11'h001 : gap_ff + 11'h001;
      seen_ff <= seen_ff | tick16;
      chg_ff  <= tick16 ? 1'b0 : chg_ff | (divisor != $past(divisor))
                 | (high_speed != $past(high_speed));
    end
  end

  baud_period_a : assert property (@(posedge clk) disable iff (!rst_n)
    tick16 && seen_ff && !chg_ff && $stable(divisor) && $stable(high_speed) |->
      gap_ff == ({3'h0, divisor} + 11'h001) * (high_speed ? 11'h001 : 11'h004))
    else $error("baud tick spacing wrong");

endmodule : aspc_baud

// ===== design/aspc_rx_filter.sv
// receive pin synchroniser and three-sample majority filter
`timescale 1ns/10ps
module aspc_rx_filter (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic tick16,
  output logic      level,
  output logic      noisy
);

  logic       meta_ff;
  logic       sync_ff;
  logic [2:0] smp_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end else begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
    end
  end

  // samples taken on the 16x tick
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      smp_ff <= 3'h7;
    end else if (tick16) begin
      smp_ff <= {smp_ff[1:0], sync_ff};
    end
  end

  assign level = (smp_ff[0] & smp_ff[1]) | (smp_ff[1] & smp_ff[2]) | (smp_ff[0] & smp_ff[2]);
  assign noisy = !(smp_ff == 3'h0 || smp_ff == 3'h7);

endmodule : aspc_rx_filter

// ===== design/aspc_core.sv
// serial port core: register slave, transmitter and receiver
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
module aspc_core
  import aspc_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        RXD,
  output logic             TXD,
  output logic             TXD_OE,
  output logic             RXD_SEL
);

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_STOP  = 3'b011,
    TX_BRK   = 3'b100
  } aspc_txst_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } aspc_rxst_t;

  aspc_ctl1_t  ctl1_ff;
  aspc_ctl2_t  ctl2_ff;
  aspc_stat_t  stat;
  logic [7:0]  baud_ff;
  logic [8:0]  tx_buf_ff;
  logic [7:0]  rx_buf_ff;
  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic        txd_ff;
  logic        txoe_ff;
  logic        rxsel_ff;
  logic        tx_empty_ff;
  logic        tx_idle_ff;
  logic        rxav_ff;
  logic        ovr_ff;
  logic        framing_error_ff;
  logic        parity_error_ff;
  logic        nf_ff;
  aspc_txst_t  tx_st_ff;
  logic [3:0]  tx_ovs_ff;
  logic [3:0]  tx_bit_ff;
  logic [8:0]  tx_sh_ff;
  logic        stop2_ff;
  aspc_rxst_t  rx_st_ff;
  logic [3:0]  rx_ovs_ff;
  logic [3:0]  rx_bit_ff;
  logic [8:0]  rx_sh_ff;
  logic        rx_nz_ff;
  logic [4:0]  stop_tk_ff;
  logic        tick16;
  logic        rx_lvl;
  logic        rx_noisy;

  //------------------------------------------------------------
  // sub blocks
  //------------------------------------------------------------
  aspc_baud u_baud (
    .clk        (CLK_SYS),
    .rst_n      (RST_N),
    .run        (ctl1_ff.en),
    .divisor    (baud_ff),
    .high_speed (ctl2_ff.hs),
    .tick16     (tick16)
  );

  aspc_rx_filter u_filt (
    .clk    (CLK_SYS),
    .rst_n  (RST_N),
    .pin    (RXD),
    .tick16 (tick16),
    .level  (rx_lvl),
    .noisy  (rx_noisy)
  );

  //------------------------------------------------------------
  // bus decode
  //------------------------------------------------------------
  wire en      = ctl1_ff.en;
  wire tx_go   = en && ctl2_ff.transmit_enable;
  wire rx_go   = en && ctl2_ff.receive_enable;
  wire commit  = AVS_WRITE && !wait_ff && AVS_BYTEENABLE[0];
  wire wr_data = commit && AVS_ADDRESS == ASPC_OFF_DATA;
  wire rd_take = AVS_READ && !wait_ff && AVS_ADDRESS == ASPC_OFF_DATA;
  wire tx_acc  = wr_data && tx_empty_ff;
  wire nine    = ctl1_ff.nine;
  wire [3:0] nlast = nine ? 4'h8 : 4'h7;

  assign stat = '{parity_error: parity_error_ff, nf: nf_ff, framing_error: framing_error_ff, ovr: ovr_ff,
                  tx_idle: tx_idle_ff, rx_idle: rx_st_ff == RX_IDLE,
                  tx_empty: tx_empty_ff, rxav: rxav_ff};

  // one wait cycle per access; data is ready when waitrequest drops
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !((AVS_READ || AVS_WRITE) && wait_ff);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rdata_ff <= 32'h0000_0000;
    end else if (AVS_READ && wait_ff) begin
      unique case (AVS_ADDRESS)
        ASPC_OFF_DATA: rdata_ff <= {24'h0, rx_buf_ff};
        ASPC_OFF_BAUD: rdata_ff <= {24'h0, baud_ff};
        ASPC_OFF_CTL1: rdata_ff <= {24'h0, ctl1_ff};
        ASPC_OFF_CTL2: rdata_ff <= {24'h0, ctl2_ff[7:4], 4'h0};
        ASPC_OFF_STAT: rdata_ff <= {24'h0, stat};
        default:       rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  //------------------------------------------------------------
  // configuration registers
  //------------------------------------------------------------
  wire rx_done = rx_go && rx_st_ff == RX_STOP && tick16 && rx_ovs_ff == ASPC_OVS_LAST;
  wire [8:0] rx_word = nine ? rx_sh_ff : {1'b0, rx_sh_ff[8:1]};
  wire addr_bit = nine ? rx_word[8] : rx_word[7];
  wire rx_keep = !(ctl2_ff.address_detect_enable && !addr_bit);
  wire rx_store = rx_done && rx_keep && !(rxav_ff && !rd_take);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ctl1_ff <= ASPC_CTL1_RST;
    end else begin
      if (commit && AVS_ADDRESS == ASPC_OFF_CTL1) begin
        ctl1_ff     <= AVS_WRITEDATA[7:0];
        ctl1_ff.rx9 <= ctl1_ff.rx9;
      end
      if (rx_store) begin
        ctl1_ff.rx9 <= nine && !ctl1_ff.pen && rx_word[8];
      end
      if (!en) begin
        ctl1_ff.brk <= 1'b0;
      end
    end
  end

  // other control bits and divisor untouched by disable
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ctl2_ff <= ASPC_CTL2_RST;
      baud_ff <= ASPC_BAUD_RST;
    end else begin
      if (commit && AVS_ADDRESS == ASPC_OFF_CTL2) begin
        ctl2_ff <= {AVS_WRITEDATA[7:4], 4'h0};
      end
      if (commit && AVS_ADDRESS == ASPC_OFF_BAUD) begin
        baud_ff <= AVS_WRITEDATA[7:0];
      end
      if (!en) begin
        ctl2_ff.transmit_enable <= 1'b0;
        ctl2_ff.receive_enable <= 1'b0;
      end
    end
  end

  //------------------------------------------------------------
  // transmit side
  //------------------------------------------------------------
  wire tx_load = tx_go && tx_st_ff == TX_IDLE && !tx_empty_ff;
  wire tx_bend = tick16 && tx_ovs_ff == ASPC_OVS_LAST;
  wire tx_done = tx_go && tx_st_ff == TX_STOP && tx_bend && !(ctl1_ff.two_stop && !stop2_ff);

  // buffered char with the ninth bit, parity put on top when enabled
  wire [8:0] tx_word = ctl1_ff.pen ?
    (nine ? {aspc_parity(tx_buf_ff, 1'b1, ctl1_ff.odd), tx_buf_ff[7:0]}
          : {1'b0, aspc_parity(tx_buf_ff, 1'b0, ctl1_ff.odd), tx_buf_ff[6:0]})
    : (nine ? tx_buf_ff : {1'b0, tx_buf_ff[7:0]});

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      tx_buf_ff <= ASPC_DATA_RST;
    end else if (tx_acc) begin
      tx_buf_ff <= {ctl1_ff.tx9, AVS_WRITEDATA[7:0]};
    end
  end

  // a busy buffer refuses the write; setting beats clearing
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || !en) begin
      tx_empty_ff <= 1'b1;
      tx_idle_ff  <= 1'b1;
    end else begin
      tx_empty_ff <= tx_load || (tx_empty_ff && !tx_acc);
      tx_idle_ff  <= tx_done || (tx_idle_ff && !wr_data);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || !tx_go) begin
      tx_st_ff  <= TX_IDLE;
      tx_ovs_ff <= 4'h0;
      tx_bit_ff <= 4'h0;
      tx_sh_ff  <= 9'h000;
      stop2_ff  <= 1'b0;
      txd_ff    <= 1'b1;
      stop_tk_ff <= 5'h00;
    end else begin
      // ticks spent in stop, watched by the stop length check
      stop_tk_ff <= (tx_st_ff != TX_STOP) ? 5'h00 : stop_tk_ff + {4'h0, tick16};
      if (tx_st_ff == TX_IDLE) begin
        tx_ovs_ff <= 4'h0;
      end else if (tick16) begin
        tx_ovs_ff <= tx_ovs_ff + 4'h1;
      end
      unique case (tx_st_ff)
        TX_IDLE: begin
          txd_ff    <= 1'b1;
          tx_bit_ff <= 4'h0;
          stop2_ff  <= 1'b0;
          if (tx_load) begin
            tx_sh_ff <= tx_word;
            tx_st_ff <= TX_START;
            txd_ff   <= 1'b0;
          end else if (ctl1_ff.brk) begin
            tx_st_ff <= TX_BRK;
            txd_ff   <= 1'b0;
          end
        end
        TX_START: if (tx_bend) begin
          tx_st_ff <= TX_DATA;
          txd_ff   <= tx_sh_ff[0];
        end
        TX_DATA: if (tx_bend) begin
          if (tx_bit_ff == nlast) begin
            tx_st_ff <= TX_STOP;
            txd_ff   <= 1'b1;
          end else begin
            tx_sh_ff  <= {1'b0, tx_sh_ff[8:1]};
            txd_ff    <= tx_sh_ff[1];
            tx_bit_ff <= tx_bit_ff + 4'h1;
          end
        end
        TX_STOP: if (tx_bend) begin
          if (ctl1_ff.two_stop && !stop2_ff) begin
            stop2_ff <= 1'b1;
          end else begin
            tx_st_ff <= TX_IDLE;
          end
        end
        TX_BRK: if (tx_bend) begin
          tx_bit_ff <= tx_bit_ff + 4'h1;
          if (tx_bit_ff == ASPC_BRK_BITS) begin
            tx_bit_ff <= 4'h1;
            if (!ctl1_ff.brk) begin
              tx_st_ff <= TX_STOP;
              txd_ff   <= 1'b1;
            end
          end
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  //------------------------------------------------------------
  // receive side
  //------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || !rx_go) begin
      rx_st_ff  <= RX_IDLE;
      rx_ovs_ff <= 4'h0;
      rx_bit_ff <= 4'h0;
      rx_sh_ff  <= 9'h000;
      rx_nz_ff  <= 1'b0;
    end else begin
      if (rx_st_ff != RX_IDLE && tick16) begin
        rx_ovs_ff <= rx_ovs_ff + 4'h1;
      end
      // only mid-bit votes count: edges between unequal bits disagree
      if (tick16 && ((rx_st_ff == RX_START && rx_ovs_ff == ASPC_OVS_MID)
          || (rx_st_ff == RX_DATA && rx_ovs_ff == ASPC_OVS_LAST))) begin
        rx_nz_ff <= rx_nz_ff | rx_noisy;
      end
      unique case (rx_st_ff)
        RX_IDLE: begin
          rx_ovs_ff <= 4'h0;
          rx_bit_ff <= 4'h0;
          rx_nz_ff  <= 1'b0;
          if (!rx_lvl) begin
            rx_st_ff <= RX_START;
          end
        end
        // glitches shorter than half a bit fall back to idle
        RX_START: if (tick16 && rx_ovs_ff == ASPC_OVS_MID) begin
          rx_ovs_ff <= 4'h0;
          rx_st_ff  <= rx_lvl ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (tick16 && rx_ovs_ff == ASPC_OVS_LAST) begin
          rx_sh_ff  <= {rx_lvl, rx_sh_ff[8:1]};
          rx_bit_ff <= rx_bit_ff + 4'h1;
          if (rx_bit_ff == nlast) begin
            rx_st_ff <= RX_STOP;
          end
        end
        RX_STOP: if (tick16 && rx_ovs_ff == ASPC_OVS_LAST) begin
          rx_st_ff <= RX_IDLE;
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // receive buffer and flags; a new event wins over the read clear
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || !en) begin
      rx_buf_ff <= 8'h00;
      rxav_ff   <= 1'b0;
      ovr_ff    <= 1'b0;
      framing_error_ff   <= 1'b0;
      parity_error_ff   <= 1'b0;
      nf_ff     <= 1'b0;
    end else begin
      if (rd_take) begin
        rxav_ff <= 1'b0;
        ovr_ff  <= 1'b0;
        framing_error_ff <= 1'b0;
        parity_error_ff <= 1'b0;
        nf_ff   <= 1'b0;
      end
      if (rx_done && rx_keep && !rx_store) begin
        ovr_ff <= 1'b1;
      end
      if (rx_store) begin
        rx_buf_ff <= (ctl1_ff.pen && !nine) ? {1'b0, rx_word[6:0]} : rx_word[7:0];
        rxav_ff   <= 1'b1;
        framing_error_ff   <= !rx_lvl;
        parity_error_ff   <= ctl1_ff.pen && (aspc_parity(rx_word, nine, ctl1_ff.odd)
                     != (nine ? rx_word[8] : rx_word[7]));
        nf_ff     <= rx_nz_ff | rx_noisy;
      end
    end
  end

  //------------------------------------------------------------
  // pins
  //------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      txoe_ff  <= 1'b0;
      rxsel_ff <= 1'b0;
    end else begin
      txoe_ff  <= tx_go;
      rxsel_ff <= rx_go;
    end
  end

  assign TXD             = txd_ff;
  assign TXD_OE          = txoe_ff;
  assign RXD_SEL         = rxsel_ff;
  assign AVS_READDATA    = rdata_ff;
  assign AVS_WAITREQUEST = wait_ff;

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  tx_idle_high_a : assert property (tx_st_ff == TX_IDLE |-> txd_ff)
    else $error("tx line not high when idle");
  start_bit_low_a : assert property (tx_st_ff == TX_START |-> !txd_ff)
    else $error("start bit not low");
  lsb_first_a : assert property (tx_st_ff == TX_DATA |-> txd_ff == tx_sh_ff[0])
    else $error("data bit order wrong");
  break_low_a : assert property (tx_st_ff == TX_BRK |-> !txd_ff)
    else $error("break not held low");
  abandon_xfer_a : assert property (!en |=> tx_st_ff == TX_IDLE && rx_st_ff == RX_IDLE)
    else $error("transfer survives disable");
  disable_flags_a : assert property (!en |=> !ctl2_ff.transmit_enable && !ctl2_ff.receive_enable && !ctl1_ff.brk
    && !rxav_ff && !ovr_ff && !framing_error_ff && !parity_error_ff && !nf_ff && tx_idle_ff && tx_empty_ff)
    else $error("disable flags wrong");
  keep_divisor_a : assert property ($fell(en) && !commit |=> $stable(baud_ff))
    else $error("divisor lost on disable");
  parity_strip_a : assert property (rx_store && ctl1_ff.pen |=> !ctl1_ff.rx9)
    else $error("parity bit stored");
  addr_drop_a : assert property (rx_done && ctl2_ff.address_detect_enable && !addr_bit && !rxav_ff
    |=> !rxav_ff) else $error("address filter failed");
  bus_answer_a : assert property ((AVS_READ || AVS_WRITE) && wait_ff |=> !wait_ff)
    else $error("no bus answer");
  stop_len_a : assert property (tx_done && ctl1_ff.two_stop
    |-> txd_ff && stop_tk_ff == 5'h1F) else $error("stop too short");

  frame_sent_c : cover property (tx_done);
  frame_got_c  : cover property (rx_store);
  overrun_c    : cover property (rx_done && rx_keep && !rx_store);
  break_sent_c : cover property (tx_st_ff == TX_BRK ##1 tx_st_ff == TX_STOP);

endmodule : aspc_core

// ===== verification/aspc_remote.sv
// remote serial device model facing the core pins
`timescale 1ns/10ps
module aspc_remote (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd,
  output logic      got,
  output logic [7:0] rx_byte
);
  int bit_clks = 16;
  initial begin
    rxd = 1'b1;
    got = 1'b0;
    rx_byte = 8'h00;
  end
  //--------------------------------------------------------------
  // sender: start, 8 bits lsb first, one stop
  //--------------------------------------------------------------
  task automatic send(input logic [7:0] d);
    @(posedge clk) rxd <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      repeat (bit_clks) @(posedge clk);
      rxd <= (i < 8) ? d[i] : 1'b1;
    end
    repeat (bit_clks) @(posedge clk);
  endtask : send
  //--------------------------------------------------------------
  // receiver: mid-bit sampling, frame kept only with a high stop
  //--------------------------------------------------------------
  always begin
    @(negedge txd);
    repeat (bit_clks / 2) @(posedge clk);
    if (txd === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (bit_clks) @(posedge clk);
        rx_byte[i] = txd;
      end
      repeat (bit_clks) @(posedge clk);
      got <= (txd === 1'b1);
      @(posedge clk) got <= 1'b0;
    end
  end
endmodule : aspc_remote

// ===== verification/aspc_core_tb.sv
// self-checking bench of the serial port core
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin n_mismatch++; \
  $display("BAD %s exp %h seen %h", n, e, s); end end
module aspc_core_tb;
  import aspc_pkg::*;
  logic        clk, rst_n, rd_en, wr_en, wreq, txd, txd_oe, rxd_sel, rxd, got;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, exp_r;
  logic [3:0]  be;
  logic [7:0]  d, rx_byte, exp_t;
  logic [31:0] rq[$];
  logic [7:0]  tq[$];
  logic [7:0]  fmt [4] = '{8'h80, 8'h88, 8'hA0, 8'hB0};
  int          n_mismatch, n_compared, seed, cyc;
  aspc_core uut (.CLK_SYS(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
    .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .RXD(rxd), .TXD(txd), .TXD_OE(txd_oe), .RXD_SEL(rxd_sel));
  aspc_remote rm (.clk(clk), .txd(txd), .rxd(rxd), .got(got), .rx_byte(rx_byte));
  always #50 clk = ~clk;
  //--------------------------------------------------------------
  // bus master: hold request until waitrequest sampled low
  //--------------------------------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
    wr_en <= w;
    rd_en <= !w;
    addr  <= a;
    wdata <= {24'h000000, v};
    do @(posedge clk); while (wreq !== 1'b0);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    rq.push_back({24'h000000, e});
    bus(1'b0, a, 8'h00);
  endtask : rd
  task automatic tx(input logic [7:0] e);
    tq.push_back(e);
    repeat (12 * rm.bit_clks) @(posedge clk);
  endtask : tx
  task automatic results;
    if ((n_mismatch == 0) && (n_compared > 0)) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  //--------------------------------------------------------------
  // watcher: oldest note against each result
  //--------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results;
    end
    if ((rd_en === 1'b1) && (wreq === 1'b0) && (rq.size() > 0)) begin
      exp_r = rq.pop_front();
      `CHK("readdata", exp_r, rdata)
    end
    if ((got === 1'b1) && (tq.size() > 0)) begin
      exp_t = tq.pop_front();
      `CHK("txd frame", exp_t, rx_byte)
    end
  end
  initial begin
    clk = 1'b0; rst_n = 1'b0; rd_en = 1'b0; wr_en = 1'b0; addr = 5'h00;
    wdata = 32'h0; be = 4'hF; seed = 92; cyc = 0; n_mismatch = 0; n_compared = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(ASPC_OFF_STAT, 8'h0E);
    rd(ASPC_OFF_CTL1, 8'h00);
    rd(5'h14, 8'h00);
    be <= 4'hE;
    bus(1'b1, ASPC_OFF_BAUD, 8'h5A);
    be <= 4'hF;
    rd(ASPC_OFF_BAUD, 8'h00);
    bus(1'b1, ASPC_OFF_BAUD, 8'h00);
    bus(1'b1, ASPC_OFF_CTL1, 8'h80);
    bus(1'b1, ASPC_OFF_CTL2, 8'hE0);
    repeat (2) @(posedge clk);
    `CHK("pins", 3'h7, {txd_oe, rxd_sel, txd})
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, ASPC_OFF_CTL1, fmt[p]);
      d = $random(seed);
      bus(1'b1, ASPC_OFF_DATA, d);
      tx((p < 2) ? d : {^d[6:0] ^ (p == 3), d[6:0]});
    end
    d = $random(seed);
    rm.send({^d[6:0] ^ 1'b1, d[6:0]});
    repeat (32) @(posedge clk);
    rd(ASPC_OFF_STAT, 8'h0F);
    rd(ASPC_OFF_DATA, {1'b0, d[6:0]});
    rd(ASPC_OFF_STAT, 8'h0E);
    // slow mode: 64 x 2 clocks per bit
    bus(1'b1, ASPC_OFF_BAUD, 8'h01);
    bus(1'b1, ASPC_OFF_CTL1, 8'h80);
    bus(1'b1, ASPC_OFF_CTL2, 8'hD0);
    rm.bit_clks = 128;
    d = $random(seed);
    bus(1'b1, ASPC_OFF_DATA, d);
    tx(d);
    // disable in mid-frame, no frame is expected from it
    bus(1'b1, ASPC_OFF_DATA, d);
    repeat (384) @(posedge clk);
    bus(1'b1, ASPC_OFF_CTL1, 8'h18);
    repeat (2) @(posedge clk);
    `CHK("released", 3'h4, {txd, txd_oe, rxd_sel})
    rd(ASPC_OFF_CTL2, 8'h10);
    rd(ASPC_OFF_CTL1, 8'h18);
    rd(ASPC_OFF_BAUD, 8'h01);
    rd(ASPC_OFF_STAT, 8'h0E);
    repeat (1536) @(posedge clk);
    bus(1'b1, ASPC_OFF_CTL1, 8'h80);
    bus(1'b1, ASPC_OFF_CTL2, 8'hD0);
    d = $random(seed);
    bus(1'b1, ASPC_OFF_DATA, d);
    tx(d);
    results;
  end
endmodule : aspc_core_tb
